// File: bench/watchdog_interval_timer_test.sv
// Testbench: self-checking bench of the watchdog / interval timer core
module watchdog_interval_timer_test
    import wdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************
    // Signals and design
    // ****************
    logic clock_i = 1'b0, rst_i = 1'b1, pin_n = 1'b1, standby_i = 1'b0;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000;
    logic rd = 1'b0, wr = 1'b0, word = 1'b1, ce = 1'b1;
    logic [7:0] rdata, v, r;
    logic irq, crst, pin, oe;
    int mismatches = 0, n_compared = 0, n, m, d;

    // Short reset widths keep the run brief
    wdt_core #(.INT_RST_CYCLES(20), .EXT_RST_CYCLES(8)) dut (
        .clock_i(clock_i), .rst_i(rst_i), .clk_en_i(ce),
        .hard_clear_pin_n_i(pin_n), .standby_i(standby_i),
        .bus_addr_i(addr), .bus_rd_i(rd), .bus_wr_i(wr), .bus_word_i(word),
        .bus_wdata_i(wdata), .bus_rdata_o(rdata), .interval_irq_o(irq),
        .chip_rst_o(crst), .rst_drive_out_n_o(pin), .rst_drive_out_oe_o(oe)
    );

    always #2.5 clock_i = ~clock_i;

    // ****************
    // Helpers
    // ****************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Strobe held one edge, then dropped off the edge
    task automatic wr16(input logic [15:0] a, input logic [15:0] dat, input logic w);
        @(posedge clock_i) #1;
        addr = a;
        wdata = dat;
        word = w;
        wr = 1'b1;
        @(posedge clock_i) #1;
        wr = 1'b0;
    endtask

    task automatic rd8(input logic [15:0] a, output logic [7:0] q);
        @(posedge clock_i) #1;
        addr = a;
        rd = 1'b1;
        @(posedge clock_i) #1;
        rd = 1'b0;
        q = rdata;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] q;
        rd8(a, q);
        chk(q, exp);
    endtask

    function automatic logic [7:0] tcs(input logic wf, fs, ce, input logic [2:0] cs);
        return {wf, fs, ce, 2'b11, cs};
    endfunction

    function automatic int div_of(input int k);
        return k == 0 ? 2 : (k < 6 ? 16 << k : 32 << k);
    endfunction

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard, well beyond the tap loop's length
    initial begin
        #400000;
        mismatches++;
        test_done();
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        void'($urandom(32'haf62));
        repeat (5) @(posedge clock_i);
        #1 rst_i = 1'b0;
        rdchk(ADDR_TCS_RD, TCS_RESET);
        rdchk(ADDR_CNT_RD, CNT_RESET);
        rdchk(ADDR_RCS_RD, RCS_FIXED_ONES);
        rdchk(ADDR_RCS_WR, 8'h00);
        // Byte write, wrong password, wrong address
        wr16(ADDR_TCS_WR, {PW_CONTROL, 8'h67}, 1'b0);
        wr16(ADDR_TCS_WR, {8'h3c, 8'h67}, 1'b1);
        wr16(ADDR_CNT_RD, {PW_CONTROL, 8'h67}, 1'b1);
        rdchk(ADDR_TCS_RD, TCS_RESET);
        // Each tap: random preload, expect four or five ticks in four tap periods
        for (int k = 0; k < 8; k++) begin
            d = div_of(k);
            v = 8'($urandom_range(8'hf0));
            wr16(ADDR_TCS_WR, {PW_CONTROL, tcs(1'b0, 1'b0, 1'b1, 3'(k))}, 1'b1);
            rdchk(ADDR_TCS_RD, tcs(1'b0, 1'b0, 1'b1, 3'(k)));
            wr16(ADDR_TCS_WR, {PW_COUNTER, v}, 1'b1);
            repeat (4 * d) @(posedge clock_i);
            rd8(ADDR_CNT_RD, r);
            chk(8'(r - v >= 4 && r - v <= 5), 8'h01);
        end
        wr16(ADDR_TCS_WR, {PW_CONTROL, 8'h00}, 1'b1);
        repeat (8) @(posedge clock_i);
        rdchk(ADDR_CNT_RD, 8'h00);
        // Interval wrap, then flag clearing
        wr16(ADDR_TCS_WR, {PW_CONTROL, tcs(1'b0, 1'b0, 1'b1, 3'h0)}, 1'b1);
        wr16(ADDR_TCS_WR, {PW_COUNTER, 8'hfe}, 1'b1);
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(posedge clock_i) #1;
            n++;
        end
        chk(8'(irq), 8'h01);
        wr16(ADDR_TCS_WR, {PW_CONTROL, tcs(1'b0, 1'b0, 1'b1, 3'h0)}, 1'b1);
        rdchk(ADDR_TCS_RD, tcs(1'b1, 1'b0, 1'b1, 3'h0));
        wr16(ADDR_TCS_WR, {PW_CONTROL, tcs(1'b0, 1'b0, 1'b1, 3'h0)}, 1'b1);
        rdchk(ADDR_TCS_RD, tcs(1'b0, 1'b0, 1'b1, 3'h0));
        wr16(ADDR_TCS_WR, {PW_CONTROL, tcs(1'b1, 1'b0, 1'b1, 3'h0)}, 1'b1);
        rdchk(ADDR_TCS_RD, tcs(1'b0, 1'b0, 1'b1, 3'h0));
        // Clock enable low freezes the running counter; one live edge may tick
        wr16(ADDR_TCS_WR, {PW_COUNTER, 8'h10}, 1'b1);
        ce = 1'b0;
        repeat (50) @(posedge clock_i);
        #1 ce = 1'b1;
        rd8(ADDR_CNT_RD, r);
        chk(8'(r >= 8'h10 && r <= 8'h11), 8'h01);
        // Standby keeps only the clock select
        wr16(ADDR_TCS_WR, {PW_CONTROL, tcs(1'b0, 1'b1, 1'b1, 3'h7)}, 1'b1);
        wr16(ADDR_TCS_WR, {PW_COUNTER, 8'h40}, 1'b1);
        standby_i = 1'b1;
        @(posedge clock_i) #1;
        standby_i = 1'b0;
        rdchk(ADDR_TCS_RD, tcs(1'b0, 1'b0, 1'b0, 3'h7));
        rdchk(ADDR_CNT_RD, 8'h00);
        // Watchdog bite with pin drive enabled
        wr16(ADDR_RCS_WR, {PW_COUNTER, 8'h40}, 1'b1);
        rdchk(ADDR_RCS_RD, 8'h7f);
        wr16(ADDR_TCS_WR, {PW_CONTROL, tcs(1'b0, 1'b1, 1'b1, 3'h0)}, 1'b1);
        wr16(ADDR_TCS_WR, {PW_COUNTER, 8'hfe}, 1'b1);
        n = 0;
        while (crst !== 1'b1 && n < 20) begin
            @(posedge clock_i) #1;
            n++;
        end
        n = 0;
        m = 0;
        while (crst === 1'b1 && n < 100) begin
            n++;
            m = m + int'(oe === 1'b1);
            @(posedge clock_i) #1;
        end
        chk(8'(n), 8'h14);
        chk(8'(m), 8'h08);
        rdchk(ADDR_RCS_RD, 8'hff);
        rdchk(ADDR_TCS_RD, TCS_RESET);
        wr16(ADDR_RCS_WR, {PW_CONTROL, RCS_CLEAR_DATA}, 1'b1);
        rdchk(ADDR_RCS_RD, 8'h7f);
        // Hard pin clears the drive enable
        pin_n = 1'b0;
        repeat (4) @(posedge clock_i);
        #1 pin_n = 1'b1;
        repeat (4) @(posedge clock_i);
        rdchk(ADDR_RCS_RD, RCS_FIXED_ONES);
        // Mid-run reset clears the drive enable as well
        wr16(ADDR_RCS_WR, {PW_COUNTER, 8'h40}, 1'b1);
        rdchk(ADDR_RCS_RD, 8'h7f);
        rst_i = 1'b1;
        @(posedge clock_i) #1;
        rst_i = 1'b0;
        rdchk(ADDR_RCS_RD, RCS_FIXED_ONES);
        rdchk(ADDR_TCS_RD, TCS_RESET);
        test_done();
    end
endmodule

// File: bench/wdt_props.sv
// Checker: port-level properties of the watchdog core
module wdt_checker
    import wdt_pkg::*;
#(
    parameter int INT_RST_CYCLES = 20,
    parameter int EXT_RST_CYCLES = 8
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Register bus
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_rdata_o,
    // Timer outputs
    input wire logic interval_irq_o,
    input wire logic chip_rst_o,
    input wire logic rst_drive_out_n_o,
    input wire logic rst_drive_out_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************
    // Pulse counters
    // ****************
    logic [9:0] run_q, run_d, oe_q, oe_d;

    // Widths too long to unroll, so count them here
    always_comb begin
        run_d = chip_rst_o ? run_q + 10'h001 : 10'h000;
        oe_d = rst_drive_out_oe_o ? oe_q + 10'h001 : 10'h000;
    end

    // Registered counts
    always_ff @(posedge clock_i) begin
        run_q <= rst_i ? 10'h000 : run_d;
        oe_q <= rst_i ? 10'h000 : oe_d;
    end

    // ****************
    // Properties
    // ****************
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    property p_pin_low; rst_drive_out_oe_o |-> rst_drive_out_n_o == 1'b0; endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin driven high");
    property p_oe_in_rst; rst_drive_out_oe_o |-> chip_rst_o; endproperty
    a_oe_in_rst: assert property (p_oe_in_rst) else $error("pin drive outside reset");
    property p_rst_len; $fell(chip_rst_o) |-> run_q == INT_RST_CYCLES; endproperty
    a_rst_len: assert property (p_rst_len) else $error("chip reset width wrong");
    property p_rst_cap; chip_rst_o |-> run_q < INT_RST_CYCLES; endproperty
    a_rst_cap: assert property (p_rst_cap) else $error("chip reset too long");
    property p_oe_len; $fell(rst_drive_out_oe_o) |-> oe_q == EXT_RST_CYCLES; endproperty
    a_oe_len: assert property (p_oe_len) else $error("pin drive width wrong");
    property p_irq_pulse; interval_irq_o |=> !interval_irq_o; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a cycle");
    property p_irq_mode; interval_irq_o |-> !chip_rst_o; endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq during chip reset");
    property p_rd_idle; !$past(bus_rd_i) |-> bus_rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_tcs_ones;
        $past(bus_rd_i) && $past(bus_addr_i) == ADDR_TCS_RD |-> bus_rdata_o[4:3] == 2'b11;
    endproperty
    a_tcs_ones: assert property (p_tcs_ones) else $error("control fixed bits wrong");
    property p_rcs_ones;
        $past(bus_rd_i) && $past(bus_addr_i) == ADDR_RCS_RD |-> bus_rdata_o[5:0] == 6'h3f;
    endproperty
    a_rcs_ones: assert property (p_rcs_ones) else $error("reset fixed bits wrong");
endmodule

bind wdt_core wdt_checker #(
    .INT_RST_CYCLES(INT_RST_CYCLES),
    .EXT_RST_CYCLES(EXT_RST_CYCLES)
) u_checker (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .bus_addr_i(bus_addr_i),
    .bus_rd_i(bus_rd_i),
    .bus_rdata_o(bus_rdata_o),
    .interval_irq_o(interval_irq_o),
    .chip_rst_o(chip_rst_o),
    .rst_drive_out_n_o(rst_drive_out_n_o),
    .rst_drive_out_oe_o(rst_drive_out_oe_o)
);

// File: design/wdt_core.sv
// Design: watchdog / interval timer with password-protected registers
module wdt_core
    import wdt_pkg::*;
#(
    parameter int INT_RST_CYCLES = INT_RST_STATES,
    parameter int EXT_RST_CYCLES = EXT_RST_STATES
) (
    // Clock, reset and enable
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Hard reset pin, asynchronous to this logic
    input wire logic hard_clear_pin_n_i,
    // Standby entry request from the power controller
    input wire logic standby_i,
    // CPU register bus
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_rd_i,
    input wire logic bus_wr_i,
    input wire logic bus_word_i,
    input wire logic [15:0] bus_wdata_i,
    output logic [7:0] bus_rdata_o,
    // Outputs of the timer
    output logic interval_irq_o,
    output logic chip_rst_o,
    output logic rst_drive_out_n_o,
    output logic rst_drive_out_oe_o
);

    // Pulse counters are RST_CNT_W wide, so longer pulses cannot be served
    if (INT_RST_CYCLES < 1 || INT_RST_CYCLES >= (1 << RST_CNT_W)) begin : g_int_range
        $error("INT_RST_CYCLES out of range");
    end
    if (EXT_RST_CYCLES < 1 || EXT_RST_CYCLES > INT_RST_CYCLES) begin : g_ext_range
        $error("EXT_RST_CYCLES out of range");
    end

    // ****************************************************************
    // Hard reset pin synchroniser
    // ****************************************************************
    logic pin_s1_q, pin_s2_q;

    // Two flops; only the second is read by the logic
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else if (clk_en_i) begin
            pin_s1_q <= hard_clear_pin_n_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    logic hard_clr;
    assign hard_clr = rst_i || !pin_s2_q;

    // ****************************************************************
    // State declarations
    // ****************************************************************
    logic [PRESC_W-1:0] presc_q, presc_d;
    logic tap_prev_q, tap_prev_d;
    logic [7:0] cnt_q, cnt_d;
    logic wrap_q, wrap_d;
    logic fsel_q, fsel_d;
    logic cen_q, cen_d;
    logic [2:0] csel_q, csel_d;
    logic wrap_seen_q, wrap_seen_d;
    logic bite_q, bite_d;
    logic bite_seen_q, bite_seen_d;
    logic rden_q, rden_d;
    logic [RST_CNT_W-1:0] irst_q, irst_d;
    logic [RST_CNT_W-1:0] erst_q, erst_d;
    logic irq_q, irq_d;
    logic [7:0] rdata_q, rdata_d;
    logic chip_rst_q, chip_rst_d;
    logic pin_low_q, pin_low_d;

    // ****************************************************************
    // Tap selection
    // ****************************************************************
    logic tap;
    logic tick;
    logic overflow;

    // Each tap is a divider bit; its rising edge is one tick
    always_comb begin
        case (csel_q)
            3'h0: tap = presc_q[0];
            3'h1: tap = presc_q[4];
            3'h2: tap = presc_q[5];
            3'h3: tap = presc_q[6];
            3'h4: tap = presc_q[7];
            3'h5: tap = presc_q[8];
            3'h6: tap = presc_q[10];
            3'h7: tap = presc_q[11];
            default: tap = presc_q[0];
        endcase
    end

    // Single-cycle pulse on rising tap edge
    assign tick = tap && !tap_prev_q;
    assign overflow = cen_q && tick && (cnt_q == 8'hff);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic wr_tcs, wr_rcs;
    logic pw_cnt, pw_ctl;

    // Byte writes never reach the registers
    assign wr_tcs = bus_wr_i && bus_word_i && (bus_addr_i == ADDR_TCS_WR);
    assign wr_rcs = bus_wr_i && bus_word_i && (bus_addr_i == ADDR_RCS_WR);
    // Password in upper byte unlocks the write
    assign pw_cnt = bus_wdata_i[15:8] == PW_COUNTER;
    assign pw_ctl = bus_wdata_i[15:8] == PW_CONTROL;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        // Divider runs freely regardless of mode
        presc_d = presc_q + {{(PRESC_W-1){1'b0}}, 1'b1};
        tap_prev_d = tap;
        cnt_d = cnt_q;
        wrap_d = wrap_q;
        fsel_d = fsel_q;
        cen_d = cen_q;
        csel_d = csel_q;
        wrap_seen_d = wrap_seen_q;
        bite_d = bite_q;
        bite_seen_d = bite_seen_q;
        rden_d = rden_q;
        irst_d = irst_q;
        erst_d = erst_q;
        irq_d = 1'b0;

        // Counter steps on a tick while enabled
        if (cen_q && tick) begin
            cnt_d = cnt_q + 8'h01;
        end
        // Password-protected counter load
        if (wr_tcs && pw_cnt) begin
            cnt_d = bus_wdata_i[7:0];
        end

        // Read of set flag arms the clear
        if (bus_rd_i && bus_addr_i == ADDR_TCS_RD && wrap_q) begin
            wrap_seen_d = 1'b1;
        end
        if (bus_rd_i && bus_addr_i == ADDR_RCS_RD && bite_q) begin
            bite_seen_d = 1'b1;
        end

        // Control write; only a 0 in bit 7 clears the flag
        if (wr_tcs && pw_ctl) begin
            if (!bus_wdata_i[BIT_WRAP] && wrap_seen_q) begin
                wrap_d = 1'b0;
                wrap_seen_d = 1'b0;
            end
            fsel_d = bus_wdata_i[BIT_FSEL];
            cen_d = bus_wdata_i[BIT_CEN];
            csel_d = bus_wdata_i[2:0];
        end

        // Reset control writes
        if (wr_rcs && pw_ctl && bus_wdata_i[7:0] == RCS_CLEAR_DATA && bite_seen_q) begin
            bite_d = 1'b0;
            bite_seen_d = 1'b0;
        end
        if (wr_rcs && pw_cnt) begin
            rden_d = bus_wdata_i[BIT_RDEN];
        end

        // Disabled counter is held at zero
        if (!cen_d) begin
            cnt_d = CNT_RESET;
        end

        // Overflow sets the flag; set beats a clear
        if (overflow) begin
            wrap_d = 1'b1;
            if (fsel_q) begin
                // Watchdog bite: start both reset pulses
                bite_d = 1'b1;
                irst_d = RST_CNT_W'(INT_RST_CYCLES);
                erst_d = RST_CNT_W'(EXT_RST_CYCLES);
            end else begin
                irq_d = 1'b1;
            end
        end else begin
            if (irst_q != '0) begin
                irst_d = irst_q - 1'b1;
            end
            if (erst_q != '0) begin
                erst_d = erst_q - 1'b1;
            end
        end

        // Standby clears bits 7..5 and the counter; the clock select is kept
        if (standby_i) begin
            wrap_d = 1'b0;
            fsel_d = 1'b0;
            cen_d = 1'b0;
            cnt_d = CNT_RESET;
            wrap_seen_d = 1'b0;
        end

        // Internal reset clears the timer but not the bite flag or drive enable
        if (irst_q != '0) begin
            cnt_d = CNT_RESET;
            wrap_d = 1'b0;
            fsel_d = 1'b0;
            cen_d = 1'b0;
            csel_d = CSEL_RESET;
            wrap_seen_d = 1'b0;
            irq_d = 1'b0;
        end

        // Read data mux; reserved bits read 1
        rdata_d = 8'h00;
        if (bus_rd_i) begin
            case (bus_addr_i)
                ADDR_TCS_RD: rdata_d = {wrap_q, fsel_q, cen_q, 2'b00, csel_q} | TCS_FIXED_ONES;
                ADDR_CNT_RD: rdata_d = cnt_q;
                ADDR_RCS_RD: rdata_d = {bite_q, rden_q, 6'h00} | RCS_FIXED_ONES;
                default: rdata_d = 8'h00;
            endcase
        end

        // Outputs from flops
        chip_rst_d = (irst_d != '0);
        pin_low_d = rden_q && (erst_d != '0);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Reset flags survive a bite; the hard pin, rst_i or a register write clears them
    always_ff @(posedge clock_i) begin
        if (hard_clr) begin
            bite_q <= 1'b0;
            bite_seen_q <= 1'b0;
            rden_q <= 1'b0;
        end else if (clk_en_i) begin
            bite_q <= bite_d;
            bite_seen_q <= bite_seen_d;
            rden_q <= rden_d;
        end
    end

    // Timer state; the hard pin also wins over a simultaneous bite
    always_ff @(posedge clock_i) begin
        if (hard_clr) begin
            presc_q <= '0;
            tap_prev_q <= 1'b0;
            cnt_q <= CNT_RESET;
            wrap_q <= TCS_RESET[BIT_WRAP];
            fsel_q <= TCS_RESET[BIT_FSEL];
            cen_q <= TCS_RESET[BIT_CEN];
            csel_q <= CSEL_RESET;
            wrap_seen_q <= 1'b0;
            irst_q <= '0;
            erst_q <= '0;
            irq_q <= 1'b0;
            rdata_q <= 8'h00;
            chip_rst_q <= 1'b0;
            pin_low_q <= 1'b0;
        end else if (clk_en_i) begin
            presc_q <= presc_d;
            tap_prev_q <= tap_prev_d;
            cnt_q <= cnt_d;
            wrap_q <= wrap_d;
            fsel_q <= fsel_d;
            cen_q <= cen_d;
            csel_q <= csel_d;
            wrap_seen_q <= wrap_seen_d;
            irst_q <= irst_d;
            erst_q <= erst_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
            chip_rst_q <= chip_rst_d;
            pin_low_q <= pin_low_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Open drain: only ever drives low
    assign bus_rdata_o = rdata_q;
    assign interval_irq_o = irq_q;
    assign chip_rst_o = chip_rst_q;
    assign rst_drive_out_n_o = 1'b0;
    assign rst_drive_out_oe_o = pin_low_q;

endmodule

// File: shared/wdt_pkg.sv
// Package: register addresses, passwords, field positions and timing counts of the watchdog
package wdt_pkg;

    // ****************************************************************
    // Register addresses (lower 16 bits)
    // ****************************************************************
    localparam logic [15:0] ADDR_TCS_WR = 16'hffa8; // Counter / control word write
    localparam logic [15:0] ADDR_TCS_RD = 16'hffa8; // timer_control_status read
    localparam logic [15:0] ADDR_CNT_RD = 16'hffa9; // watchdog_counter read
    localparam logic [15:0] ADDR_RCS_WR = 16'hffaa; // reset_control_status write
    localparam logic [15:0] ADDR_RCS_RD = 16'hffab; // reset_control_status read

    // ****************************************************************
    // Passwords and special data
    // ****************************************************************
    localparam logic [7:0] PW_COUNTER = 8'h5a;
    localparam logic [7:0] PW_CONTROL = 8'ha5;
    localparam logic [7:0] RCS_CLEAR_DATA = 8'h00;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int BIT_WRAP = 7;
    localparam int BIT_FSEL = 6;
    localparam int BIT_CEN = 5;
    localparam int BIT_BITE = 7;
    localparam int BIT_RDEN = 6;
    localparam logic [7:0] TCS_RESET = 8'h18;
    localparam logic [7:0] TCS_FIXED_ONES = 8'h18;
    localparam logic [7:0] RCS_FIXED_ONES = 8'h3f;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [2:0] CSEL_RESET = 3'h0;

    // ****************************************************************
    // Prescaler and reset pulse lengths (in system clock states)
    // ****************************************************************
    localparam int PRESC_W = 12;
    localparam int INT_RST_STATES = 518;
    localparam int EXT_RST_STATES = 132;
    localparam int RST_CNT_W = 10;

endpackage
